/* src/tpa_pkg.sv */
// How it works
// - 8-bit count, 0.0196 V steps, max 240
// - Percent is span ratio times 100
// - Init idle point is stored low plus 15
// - Init full point is stored high minus 15
// - Set points track lowest and highest samples in run state, only the highest during recal
// - Idle below 14 raises code 21 12
// - Full above 233 raises code 21 23
// - Error zone forces 100 percent until recalibrated
// - Code clear alone keeps forced 100 percent
// - Tool reset captures present count as idle
// - After reset full equals idle until movement
// - Full point follows maximum travel after reset
package tpa_pkg;
    localparam logic [7:0] TPA_COUNT_MAX = 8'hF0;
    localparam logic [7:0] TPA_BACKOFF = 8'h0F;
    localparam logic [7:0] TPA_LOW_ZONE = 8'h0E;
    localparam logic [7:0] TPA_HIGH_ZONE = 8'hE9;
    localparam logic [6:0] TPA_PCT_FULL = 7'h64;
    localparam logic [15:0] TPA_CODE_LOW = 16'h2112;
    localparam logic [15:0] TPA_CODE_HIGH = 16'h2123;
    localparam logic [11:0] TPA_REG_CTRL = 12'h000;
    localparam logic [11:0] TPA_REG_STATUS = 12'h004;
    localparam logic [11:0] TPA_REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] TPA_REG_IRQ_EN = 12'h00C;
    localparam logic [11:0] TPA_REG_IRQ_CLR = 12'h010;
    localparam logic [11:0] TPA_REG_POINTS = 12'h014;
    localparam logic [11:0] TPA_REG_STORE = 12'h018;
    localparam logic [11:0] TPA_REG_CODE = 12'h01C;
    localparam int TPA_CTRL_INIT = 0;
    localparam int TPA_CTRL_RECAL = 1;
    localparam int TPA_CTRL_CLRCODE = 2;
    localparam logic [1:0] TPA_RESP_OKAY = 2'h0;
    localparam logic [1:0] TPA_RESP_SLVERR = 2'h2;
    localparam int TPA_IRQ_W = 3;
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
    } tpa_points_t;
    typedef enum logic [1:0] {
        TPA_ST_IDLE = 2'b00,
        TPA_ST_RUN = 2'b01,
        TPA_ST_RECAL = 2'b10
    } tpa_state_t;
endpackage

/* src/tpa_percent.sv */
`timescale 1ns/1ps
module tpa_percent (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] count,
    input wire tpa_pkg::tpa_points_t pts,
    input wire logic force_full,
    output logic [6:0] pct_q
);
    logic [7:0] span;
    logic [7:0] rise;
    logic [14:0] num;
    logic [14:0] quo;
    logic [6:0] pct_d;
    always_comb begin
        span = pts.high - pts.low;
        rise = (count > pts.low) ? count - pts.low : 8'h00;
        num = 15'(rise) * 15'(tpa_pkg::TPA_PCT_FULL);
        quo = (span == 8'h00) ? 15'h0000 : num / 15'(span);
        if (pts.high <= pts.low) begin
            pct_d = 7'h00;
        end else if (quo > 15'(tpa_pkg::TPA_PCT_FULL)) begin
            pct_d = tpa_pkg::TPA_PCT_FULL;
        end else begin
            pct_d = quo[6:0];
        end
        if (force_full) begin
            pct_d = tpa_pkg::TPA_PCT_FULL;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pct_q <= 7'h00;
        end else begin
            pct_q <= pct_d;
        end
    end
endmodule

/* src/tpa_core.sv */
`timescale 1ns/1ps
module tpa_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] sample,
    input wire logic sample_valid,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [6:0] pct_q,
    output logic force_full_q,
    output logic irq_q
);
    tpa_pkg::tpa_state_t state_q;
    tpa_pkg::tpa_points_t pts_q;
    tpa_pkg::tpa_points_t store_q;
    logic [7:0] count_q;
    logic [7:0] recal_cnt_q;
    logic code_low_q;
    logic code_high_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    logic [2:0] irq_ev;
    logic [2:0] irq_clr;
    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic wr_ok;
    logic cmd_init;
    logic cmd_recal;
    logic cmd_clrcode;
    logic err_low;
    logic err_high;
    logic [7:0] samp_c;

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] r);
        reg_hit = (a[11:2] == r[11:2]);
    endfunction

    assign samp_c = (sample > tpa_pkg::TPA_COUNT_MAX) ? tpa_pkg::TPA_COUNT_MAX : sample;
    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_ok = reg_hit(aw_addr_q, tpa_pkg::TPA_REG_CTRL)
        || reg_hit(aw_addr_q, tpa_pkg::TPA_REG_IRQ_EN)
        || reg_hit(aw_addr_q, tpa_pkg::TPA_REG_IRQ_CLR)
        || reg_hit(aw_addr_q, tpa_pkg::TPA_REG_STORE);
    assign cmd_init = wr_go && reg_hit(aw_addr_q, tpa_pkg::TPA_REG_CTRL)
        && w_strb_q[0] && w_data_q[tpa_pkg::TPA_CTRL_INIT];
    assign cmd_recal = wr_go && reg_hit(aw_addr_q, tpa_pkg::TPA_REG_CTRL)
        && w_strb_q[0] && w_data_q[tpa_pkg::TPA_CTRL_RECAL];
    assign cmd_clrcode = wr_go && reg_hit(aw_addr_q, tpa_pkg::TPA_REG_CTRL)
        && w_strb_q[0] && w_data_q[tpa_pkg::TPA_CTRL_CLRCODE];
    assign err_low = (state_q != tpa_pkg::TPA_ST_IDLE) && (pts_q.low < tpa_pkg::TPA_LOW_ZONE);
    assign err_high = (state_q == tpa_pkg::TPA_ST_RUN)
        && (pts_q.high > tpa_pkg::TPA_HIGH_ZONE);
    assign irq_ev = {cmd_recal, err_high && !code_high_q, err_low && !code_low_q};
    assign irq_clr = (wr_go && reg_hit(aw_addr_q, tpa_pkg::TPA_REG_IRQ_CLR) && w_strb_q[0])
        ? w_data_q[2:0] : 3'b000;

    // Write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[11:0];
            end else if (wr_go) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tpa_pkg::TPA_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? tpa_pkg::TPA_RESP_OKAY : tpa_pkg::TPA_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read side, one outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tpa_pkg::TPA_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= tpa_pkg::TPA_RESP_OKAY;
                if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_CTRL)) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_STATUS)) begin
                    s_axi_rdata <= {12'h000, state_q, force_full_q,
                        code_high_q, code_low_q, pct_q, count_q};
                end else if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_IRQ_STAT)) begin
                    s_axi_rdata <= {29'h0000_0000, irq_stat_q};
                end else if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_IRQ_EN)) begin
                    s_axi_rdata <= {29'h0000_0000, irq_en_q};
                end else if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_IRQ_CLR)) begin
                    s_axi_rdata <= 32'h0000_0000;
                end else if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_POINTS)) begin
                    s_axi_rdata <= {16'h0000, pts_q};
                end else if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_STORE)) begin
                    s_axi_rdata <= {16'h0000, store_q};
                end else if (reg_hit(s_axi_araddr[11:0], tpa_pkg::TPA_REG_CODE)) begin
                    s_axi_rdata <= {code_high_q ? tpa_pkg::TPA_CODE_HIGH : 16'h0000,
                        code_low_q ? tpa_pkg::TPA_CODE_LOW : 16'h0000};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= tpa_pkg::TPA_RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 8'h00;
        end else if (sample_valid) begin
            count_q <= samp_c;
        end
    end

    // Calibration state and set points
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= tpa_pkg::TPA_ST_IDLE;
            pts_q <= '0;
            recal_cnt_q <= 8'h00;
        end else if (cmd_recal) begin
            state_q <= tpa_pkg::TPA_ST_RECAL;
            pts_q.low <= count_q;
            pts_q.high <= count_q;
            recal_cnt_q <= count_q;
        end else if (cmd_init) begin
            state_q <= tpa_pkg::TPA_ST_RUN;
            pts_q.low <= (store_q.low > tpa_pkg::TPA_COUNT_MAX - tpa_pkg::TPA_BACKOFF)
                ? tpa_pkg::TPA_COUNT_MAX : store_q.low + tpa_pkg::TPA_BACKOFF;
            pts_q.high <= (store_q.high < tpa_pkg::TPA_BACKOFF)
                ? 8'h00 : store_q.high - tpa_pkg::TPA_BACKOFF;
        end else if (sample_valid) begin
            case (state_q)
                tpa_pkg::TPA_ST_IDLE: begin
                    state_q <= tpa_pkg::TPA_ST_IDLE;
                end
                tpa_pkg::TPA_ST_RECAL: begin
                    if (samp_c > pts_q.high) begin
                        pts_q.high <= samp_c;
                    end
                    if (samp_c != recal_cnt_q) begin
                        state_q <= tpa_pkg::TPA_ST_RUN;
                    end
                end
                tpa_pkg::TPA_ST_RUN: begin
                    if (samp_c < pts_q.low) begin
                        pts_q.low <= samp_c;
                    end
                    if (samp_c > pts_q.high) begin
                        pts_q.high <= samp_c;
                    end
                end
                default: begin
                    state_q <= tpa_pkg::TPA_ST_IDLE;
                end
            endcase
        end
    end

    // retained extremes, reset only by software write
    always_ff @(posedge aclk) begin
        if (wr_go && reg_hit(aw_addr_q, tpa_pkg::TPA_REG_STORE) && w_strb_q[1]) begin
            store_q.low <= w_data_q[15:8];
        end else if (state_q != tpa_pkg::TPA_ST_IDLE && pts_q.low < store_q.low) begin
            store_q.low <= pts_q.low;
        end
        if (wr_go && reg_hit(aw_addr_q, tpa_pkg::TPA_REG_STORE) && w_strb_q[0]) begin
            store_q.high <= w_data_q[7:0];
        end else if (state_q != tpa_pkg::TPA_ST_IDLE && pts_q.high > store_q.high) begin
            store_q.high <= pts_q.high;
        end
    end

    // Codes clearable, force is not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_low_q <= 1'b0;
            code_high_q <= 1'b0;
            force_full_q <= 1'b0;
        end else begin
            code_low_q <= err_low || (code_low_q && !cmd_clrcode);
            code_high_q <= err_high || (code_high_q && !cmd_clrcode);
            // release only on recal
            // Recal wins: the error seen here is judged on the old points
            if (cmd_recal) begin
                force_full_q <= 1'b0;
            end else if (err_low || err_high) begin
                force_full_q <= 1'b1;
            end
        end
    end

    // Set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 3'b000;
            irq_en_q <= 3'b000;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
            if (wr_go && reg_hit(aw_addr_q, tpa_pkg::TPA_REG_IRQ_EN) && w_strb_q[0]) begin
                irq_en_q <= w_data_q[2:0];
            end
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    tpa_percent u_pct (
        .aclk(aclk),
        .aresetn(aresetn),
        .count(count_q),
        .pts(pts_q),
        .force_full(force_full_q),
        .pct_q(pct_q)
    );
endmodule

/* tb/tpa_properties.sv */
`timescale 1ns/1ps
module tpa_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] pct_q,
    input wire logic force_full_q,
    input wire logic irq_q
);
    logic [3:0] w_age_q;
    // Cycles since a write beat, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_age_q <= 4'hF;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_age_q <= 4'h0;
        end else if (w_age_q != 4'hF) begin
            w_age_q <= w_age_q + 4'h1;
        end
    end
    property p_reset_quiet;
        @(posedge aclk) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq_q
            && !force_full_q && pct_q == 7'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared");
    property p_b_answer;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("no write response");
    property p_r_answer;
        @(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("no read response");
    property p_r_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_pct_range;
        @(posedge aclk) disable iff (!aresetn) pct_q <= 7'h64;
    endproperty
    a_pct_range: assert property (p_pct_range) else $error("percent above full");
    property p_force_full;
        @(posedge aclk) disable iff (!aresetn) force_full_q [*3] |-> pct_q == 7'h64;
    endproperty
    a_force_full: assert property (p_force_full) else $error("forced percent wrong");
    property p_force_release;
        @(posedge aclk) disable iff (!aresetn) $fell(force_full_q) |-> w_age_q < 4'h8;
    endproperty
    a_force_release: assert property (p_force_release) else $error("force fell alone");
    property p_irq_sticky;
        @(posedge aclk) disable iff (!aresetn) $fell(irq_q) |-> w_age_q < 4'h8;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell alone");
endmodule
bind tpa_core tpa_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pct_q, .force_full_q, .irq_q);

/* tb/tpa_sensor_model.sv */
`timescale 1ns/1ps
module tpa_sensor_model (
    input wire logic aclk,
    input wire logic [7:0] level,
    output logic [7:0] sample,
    output logic sample_valid
);
    logic [1:0] tick_q = 2'h0;
    initial begin
        sample = 8'h00;
        sample_valid = 1'b0;
    end
    always @(posedge aclk) begin
        tick_q <= tick_q + 2'h1;
        sample_valid <= (tick_q == 2'h0);
        // Raw code, the device must clip it
        if (tick_q == 2'h0) begin
            sample <= level;
        end else begin
            // Inverted and stale count alternate between conversions
            sample <= ~sample;
        end
    end
endmodule

/* tb/tpa_tb_top.sv */
`timescale 1ns/1ps
module throttle_percent_autocal_tb_top;
    localparam logic [1:0] OK = tpa_pkg::TPA_RESP_OKAY;
    localparam logic [1:0] ER = tpa_pkg::TPA_RESP_SLVERR;
    localparam logic [11:0] CT = tpa_pkg::TPA_REG_CTRL;
    localparam logic [11:0] ST = tpa_pkg::TPA_REG_STATUS;
    localparam logic [11:0] PT = tpa_pkg::TPA_REG_POINTS;
    localparam logic [11:0] IS = tpa_pkg::TPA_REG_IRQ_STAT;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] M3 = 32'h0000_0007;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] level = 8'h00;
    logic [7:0] sample;
    logic sample_valid;
    logic [31:0] s_axi_awaddr = 32'h0000_0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_araddr = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [6:0] pct_q;
    logic force_full_q, irq_q;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    always #5 aclk = ~aclk;
    tpa_sensor_model u_sensor (.aclk, .level, .sample, .sample_valid);
    tpa_core DUT (.aclk, .aresetn, .sample, .sample_valid, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pct_q, .force_full_q, .irq_q);
    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] ex);
        n_compared++;
        if (seen !== ex) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        @(posedge aclk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= {20'h0_0000, a};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok && s_axi_bvalid));
        s_axi_bready <= 1'b0;
        chk("bresp", {32'h0000_0000, s_axi_bresp}, {32'h0000_0000, er});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [1:0] er,
        input logic [31:0] ex, input string nm);
        @(posedge aclk);
        s_axi_araddr <= {20'h0_0000, a};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(nm, {s_axi_rresp, s_axi_rdata & m}, {er, ex});
    endtask
    task automatic put(input logic [7:0] v);
        level <= v;
        repeat (12) @(posedge aclk);
    endtask
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    initial begin
        do_reset();
        rd(ST, ALL, OK, 32'h0000_0000, "status");
        wr(tpa_pkg::TPA_REG_STORE, 32'h0000_28C8, OK);
        do_reset();
        rd(tpa_pkg::TPA_REG_STORE, 32'h0000_FFFF, OK, 32'h0000_28C8, "store");
        put(8'h78);
        wr(CT, 32'h0000_0001, OK);
        rd(PT, ALL, OK, 32'h0000_37B9, "points");
        rd(ST, ALL, OK, 32'h0004_3278, "status");
        put(8'h32);
        put(8'hDC);
        put(8'h87);
        rd(PT, ALL, OK, 32'h0000_32DC, "points");
        rd(ST, ALL, OK, 32'h0004_3287, "status");
        chk("pct", {27'h0, pct_q}, 34'h32);
        put(8'hFA);
        rd(ST, ALL, OK, 32'h0007_64F0, "status");
        chk("force", {33'h0, force_full_q}, 34'h1);
        chk("pct", {27'h0, pct_q}, 34'h64);
        rd(tpa_pkg::TPA_REG_CODE, ALL, OK, 32'h2123_0000, "code");
        rd(IS, M3, OK, 32'h0000_0002, "irq_stat");
        chk("irq", {33'h0, irq_q}, 34'h0);
        wr(tpa_pkg::TPA_REG_IRQ_EN, M3, OK);
        repeat (2) @(posedge aclk);
        chk("irq", {33'h0, irq_q}, 34'h1);
        wr(CT, 32'h0000_0004, OK);
        rd(ST, ALL, OK, 32'h0007_64F0, "status");
        put(8'h64);
        wr(CT, 32'h0000_0001, OK);
        wr(CT, 32'h0000_0004, OK);
        rd(ST, ALL, OK, 32'h0006_6464, "status");
        wr(CT, 32'h0000_0002, OK);
        rd(PT, ALL, OK, 32'h0000_6464, "points");
        wr(CT, 32'h0000_0004, OK);
        rd(ST, ALL, OK, 32'h0008_0064, "status");
        rd(IS, M3, OK, 32'h0000_0006, "irq_stat");
        wr(tpa_pkg::TPA_REG_IRQ_CLR, M3, OK);
        rd(IS, M3, OK, 32'h0000_0000, "irq_stat");
        chk("irq", {33'h0, irq_q}, 34'h0);
        put(8'hB4);
        put(8'h8C);
        rd(PT, ALL, OK, 32'h0000_64B4, "points");
        rd(ST, 32'h0003_FFFF, OK, 32'h0000_328C, "status");
        put(8'h0A);
        wr(CT, 32'h0000_0002, OK);
        rd(ST, 32'h0003_FF00, OK, 32'h0002_E400, "status");
        rd(tpa_pkg::TPA_REG_CODE, ALL, OK, 32'h0000_2112, "code");
        rd(12'h040, ALL, ER, 32'h0000_0000, "unmapped");
        wr(ST, 32'h0000_0000, ER);
        stop_test();
    end
endmodule
